// *** core/octal_dac_serial_loader.sv ***
// Serial loader for eight 8-bit channel registers with daisy chain output.
// Assumes the host meets setup and hold on serial_in, load_strobe and
// half_scale_force_n around ser_clk edges; ser_clk may still pulse while loading.
//
// Contract
// RL1 - Shift happens only on rising serial clock edges.
// RL2 - Rising edge with load low and preset high shifts one bit in and out.
// RL3 - A bit appears at serial output exactly twelve rising edges later.
// RL4 - Words are 12 bits: 4-bit address then 8 data bits.
// RL5 - While load is high, clock and data are ignored; shift register holds.
// RL6 - Load rising with preset high copies data into the addressed channel.
// RL7 - A load changes only the addressed channel register.
// RL8 - Preset low forces all eight channel registers to hex 80.
// RL9 - Preset acts asynchronously, at any time, regardless of serial clock.
// RL10 - Action happens on load strobe rising edge: decode and write.
// RL11 - Eight address codes, including zero, are no-ops changing nothing.
// RL12 - Host raises load after the twelfth edge, before a thirteenth.
// RL13 - First bit in is address MSB; codes 1 to 8 select A to H.
`timescale 1ns/1ns
module octal_dac_serial_loader
  import dac_loader_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic half_scale_force_n,
  output logic serial_out,
  output chan_bank_t chan_q
);

  // Link side: shift register clocked by the serial clock
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic shift_en;

  // RL5 ignore while loading
  assign shift_en = !load_strobe && half_scale_force_n;

  always_comb begin
    shift_d = shift_q;
    // RL2 one bit per edge
    if (shift_en) begin
      shift_d = {shift_q[WORD_BITS-2:0], serial_in};
    end
  end

  // RL1 rising edges only
  always_ff @(posedge ser_clk) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  // RL3 twelve-stage chain end
  assign serial_out = shift_q[WORD_BITS-1];

  // System side: three-stage synchronisers for the strobe and the preset
  logic [2:0] ld_sync_q;
  logic [2:0] ld_sync_d;
  logic [2:0] pr_sync_q;
  logic [2:0] pr_sync_d;
  logic ld_level_q;
  logic ld_level_d;
  logic pr_level_q;
  logic pr_level_d;
  logic load_rise;

  always_comb begin
    ld_sync_d = {ld_sync_q[1:0], load_strobe};
    pr_sync_d = {pr_sync_q[1:0], half_scale_force_n};
    ld_level_d = (ld_sync_q[1] == ld_sync_q[2]) ? ld_sync_q[2] : ld_level_q;
    pr_level_d = (pr_sync_q[1] == pr_sync_q[2]) ? pr_sync_q[2] : pr_level_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ld_sync_q <= 3'h0;
      pr_sync_q <= 3'h7;
      ld_level_q <= 1'b0;
      pr_level_q <= 1'b1;
    end else begin
      ld_sync_q <= ld_sync_d;
      pr_sync_q <= pr_sync_d;
      ld_level_q <= ld_level_d;
      pr_level_q <= pr_level_d;
    end
  end

  // RL10 act on strobe rising
  assign load_rise = ld_level_d && !ld_level_q && pr_level_d;

  // The word is frozen while the strobe is high, so it is safe to sample here
  ser_word_t word;
  chan_sel_t sel;
  chan_bank_t chan_d;

  // RL4 address and data fields
  assign word = ser_word_t'(shift_q);
  // RL13 address decode
  assign sel = decode_addr(word.addr);

  always_comb begin
    chan_d = chan_q;
    // RL6 write addressed channel
    // RL7 others untouched
    // RL11 no-op codes skip
    if (load_rise && sel.hit) begin
      chan_d[sel.idx] = word.data;
    end
  end

  // RL8 force half scale
  // RL9 preset is asynchronous
  always_ff @(posedge sys_clk or negedge half_scale_force_n) begin
    if (!half_scale_force_n) begin
      chan_q <= {NUM_CHAN{HALF_SCALE}};
    end else if (!rst_n) begin
      chan_q <= {NUM_CHAN{HALF_SCALE}};
    end else begin
      chan_q <= chan_d;
    end
  end

  // Helper: consecutive shifting edges, saturating
  logic [3:0] run_q;
  logic [3:0] run_d;

  always_comb begin
    run_d = 4'h0;
    if (shift_en) begin
      run_d = (run_q == 4'hf) ? run_q : run_q + 4'h1;
    end
  end

  always_ff @(posedge ser_clk) begin
    if (!rst_n) begin
      run_q <= 4'h0;
    end else begin
      run_q <= run_d;
    end
  end

  // Helper: byte mask of the channels a load would keep; the addressed byte is zero
  logic [NUM_CHAN*DATA_BITS-1:0] keep_mask;

  always_comb begin
    keep_mask = '1;
    if (sel.hit) begin
      keep_mask[sel.idx*DATA_BITS +: DATA_BITS] = 8'h00;
    end
  end

  sequence s_shifting;
    !load_strobe && half_scale_force_n;
  endsequence

  sequence s_load_hit;
    load_rise && sel.hit;
  endsequence

  a_shift_hold_load: assert property (  // RL5
    @(posedge ser_clk) disable iff (!rst_n)
    load_strobe |=> $stable(shift_q))
    else $error("shift register moved while load was high");

  a_shift_one_bit: assert property (  // RL2
    @(posedge ser_clk) disable iff (!rst_n)
    s_shifting |=> shift_q == {$past(shift_q[WORD_BITS-2:0]), $past(serial_in)})
    else $error("shift did not take one bit from the serial input");

  a_chain_twelve: assert property (  // RL3
    @(posedge ser_clk) disable iff (!rst_n)
    (run_q >= CHAIN_DEPTH) |-> serial_out == $past(serial_in, 12))
    else $error("serial output is not the input from twelve edges back");

  a_preset_half: assert property (  // RL8
    @(posedge sys_clk) disable iff (!rst_n)
    !half_scale_force_n |-> chan_q == {NUM_CHAN{HALF_SCALE}})
    else $error("channels not at half scale under preset");

  a_load_writes: assert property (  // RL6
    @(posedge sys_clk) disable iff (!rst_n)
    s_load_hit |=>
      (!half_scale_force_n || chan_q[$past(sel.idx)] == $past(word.data)))
    else $error("addressed channel did not take the data field");

  a_load_others_keep: assert property (  // RL7
    @(posedge sys_clk) disable iff (!rst_n)
    load_rise |=> (!half_scale_force_n ||
      ((chan_q ^ $past(chan_q)) & $past(keep_mask)) == '0))
    else $error("a channel other than the addressed one changed");

  a_nop_no_change: assert property (  // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    load_rise && !sel.hit |=> (!half_scale_force_n || $stable(chan_q)))
    else $error("no-op address changed a channel");

  a_idle_no_write: assert property (  // RL10
    @(posedge sys_clk) disable iff (!rst_n)
    !load_rise && half_scale_force_n |=> (!half_scale_force_n || $stable(chan_q)))
    else $error("channel changed without a load strobe edge");

  a_load_lag: assert property (  // RL10
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(ld_sync_q[2]) && ld_sync_q[1] && pr_level_q && pr_sync_q[1] && pr_sync_q[2]
      |-> load_rise || ld_level_q)
    else $error("stable strobe rise was not acted on");

  // Reset, preset and decode checks
  sequence s_preset_low;
    !half_scale_force_n;
  endsequence

  sequence s_zero_load;
    load_rise && word.addr == 4'h0;
  endsequence

  a_shift_reset_clear: assert property (  // RL2
    @(posedge ser_clk)
    !rst_n |=> shift_q == '0)
    else $error("shift register not cleared by reset");

  a_out_reset_low: assert property (  // RL3
    @(posedge ser_clk)
    !rst_n |=> serial_out == 1'b0)
    else $error("serial output not low after reset");

  a_shift_in_lsb: assert property (  // RL2
    @(posedge ser_clk) disable iff (!rst_n)
    s_shifting |=> shift_q[0] == $past(serial_in))
    else $error("serial input bit did not enter the first stage");

  a_preset_no_shift: assert property (  // RL2
    @(posedge ser_clk) disable iff (!rst_n)
    s_preset_low |=> $stable(shift_q))
    else $error("shift register moved while preset was low");

  a_out_hold_load: assert property (  // RL5
    @(posedge ser_clk) disable iff (!rst_n)
    load_strobe |=> $stable(serial_out))
    else $error("serial output moved while load was high");

  a_chan_reset_half: assert property (  // RL8
    @(posedge sys_clk)
    !rst_n |=> chan_q == {NUM_CHAN{HALF_SCALE}})
    else $error("channels not at half scale after reset");

  a_preset_release_half: assert property (  // RL9
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(half_scale_force_n) |-> chan_q == {NUM_CHAN{HALF_SCALE}})
    else $error("channels left half scale before preset release");

  a_load_once: assert property (  // RL10
    @(posedge sys_clk) disable iff (!rst_n)
    load_rise |=> !load_rise)
    else $error("one strobe edge was acted on twice");

  a_zero_code_idle: assert property (  // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    s_zero_load |=> (!half_scale_force_n || $stable(chan_q)))
    else $error("all-zeros address changed a channel");

  a_nop_high_codes: assert property (  // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    load_rise && word.addr > 4'h8 |=> (!half_scale_force_n || $stable(chan_q)))
    else $error("upper no-op address changed a channel");

  a_hit_not_zero: assert property (  // RL11
    @(posedge sys_clk) disable iff (!rst_n)
    sel.hit |-> word.addr != 4'h0)
    else $error("all-zeros address decoded as a channel");

  a_decode_window: assert property (  // RL13
    @(posedge sys_clk) disable iff (!rst_n)
    load_rise |-> sel.hit == (word.addr >= 4'h1 && word.addr <= 4'h8))
    else $error("address decode window is wrong");

  a_decode_index: assert property (  // RL13
    @(posedge sys_clk) disable iff (!rst_n)
    load_rise && sel.hit |-> 4'(sel.idx) + 4'h1 == word.addr)
    else $error("address selected the wrong channel");

  // Synchroniser levels follow two agreeing stages
  a_ld_level_high: assert property (  // RL10
    @(posedge sys_clk) disable iff (!rst_n)
    ld_sync_q[1] && ld_sync_q[2] |=> ld_level_q)
    else $error("agreed high strobe level was not taken");

  a_ld_level_low: assert property (  // RL10
    @(posedge sys_clk) disable iff (!rst_n)
    !ld_sync_q[1] && !ld_sync_q[2] |=> !ld_level_q)
    else $error("agreed low strobe level was not taken");

  a_pr_level_high: assert property (  // RL9
    @(posedge sys_clk) disable iff (!rst_n)
    pr_sync_q[1] && pr_sync_q[2] |=> pr_level_q)
    else $error("agreed high preset level was not taken");

  a_pr_level_low: assert property (  // RL9
    @(posedge sys_clk) disable iff (!rst_n)
    !pr_sync_q[1] && !pr_sync_q[2] |=> !pr_level_q)
    else $error("agreed low preset level was not taken");

endmodule

// *** common/dac_loader_pkg.sv ***
// Constants and carrier types for the octal converter serial loader.
// Assumes one system clock of 100 MHz and a serial clock from the host.
package dac_loader_pkg;

  localparam int WORD_BITS = 12;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 8;
  localparam int NUM_CHAN = 8;
  localparam int CHAN_IDX_BITS = 3;

  // Field positions inside the serial word, first bit in lands at the top
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;

  // Half scale value forced by preset and by reset
  localparam logic [7:0] HALF_SCALE = 8'h80;

  // Address of channel A; the next seven codes select B through H
  localparam logic [3:0] CHAN_BASE_ADDR = 4'h1;

  // Length of a clean shifting run after which the output is defined
  localparam logic [3:0] CHAIN_DEPTH = 4'hc;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } ser_word_t;

  typedef logic [NUM_CHAN-1:0][DATA_BITS-1:0] chan_bank_t;

  typedef struct packed {
    logic hit;
    logic [CHAN_IDX_BITS-1:0] idx;
  } chan_sel_t;

  // Address to channel decode; anything outside the window is a no-op code
  function automatic chan_sel_t decode_addr(input logic [3:0] addr);
    chan_sel_t sel;
    logic [3:0] off;
    off = addr - CHAN_BASE_ADDR;
    sel.hit = (addr >= CHAN_BASE_ADDR) && (off < 4'h8);
    sel.idx = off[2:0];
    return sel;
  endfunction

endpackage

// *** tb/host_model.sv ***
// Host side of the three-wire serial link: clock, data and load strobe.
// Assumes the loader samples on ser_clk rise; the clock stands low between frames.
`timescale 1ns/1ns
module host_model
  import dac_loader_pkg::*;
(
  output logic ser_clk,
  output logic serial_in,
  output logic load_strobe,
  input wire logic serial_out
);
  logic [11:0] seen;
  initial begin
    ser_clk = 1'b0;
    serial_in = 1'b0;
    load_strobe = 1'b0;
    seen = 12'h000;
  end
  task automatic send(input ser_word_t w, input bit ld);
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      serial_in = w[i];
      #15 seen = {seen[10:0], serial_out};
      #1 ser_clk = 1'b1;
      #16 ser_clk = 1'b0;
    end
    // Released data line shows no stale value
    serial_in = ~serial_in;
    if (ld) begin
      #16 load_strobe = 1'b1;
      // one clock edge while loading must be ignored
      #32 ser_clk = 1'b1;
      #16 ser_clk = 1'b0;
      #32 load_strobe = 1'b0;
      #80;
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the octal serial loader.
// Assumes the host model drives the link; sys_clk and preset come from here.
`timescale 1ns/1ns
module tb_top;
  import dac_loader_pkg::*;
  logic sys_clk, rst_n, half_scale_force_n, ser_clk, serial_in, load_strobe, serial_out;
  chan_bank_t chan_q, exp_bank;
  logic [75:0] exp_q[$];
  ser_word_t prev;
  logic [11:0] seen_exp;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'h5b75;
  event chk_ev;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  octal_dac_serial_loader i_octal_dac_serial_loader(.sys_clk(sys_clk), .rst_n(rst_n),
    .ser_clk(ser_clk), .serial_in(serial_in), .load_strobe(load_strobe),
    .half_scale_force_n(half_scale_force_n), .serial_out(serial_out), .chan_q(chan_q));
  host_model i_host_model(.ser_clk(ser_clk), .serial_in(serial_in),
    .load_strobe(load_strobe), .serial_out(serial_out));
  task automatic cmp(input logic [75:0] got, input logic [75:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  initial forever begin
    @(chk_ev);
    cmp({i_host_model.seen, chan_q}, exp_q.pop_front());
  end
  task automatic note(input logic [11:0] s);
    seen_exp = s;
    exp_q.push_back({s, exp_bank});
    -> chk_ev;
  endtask
  task automatic load(input int a, input logic [7:0] d);
    ser_word_t w;
    w = {4'(a), d};
    i_host_model.send(w, 1'b1);
    if (half_scale_force_n === 1'b1) begin
      if (a >= 1 && a <= 8) exp_bank[a-1] = d;
      note(prev);
      prev = w;
    end else begin
      note({12{prev[11]}});
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    half_scale_force_n = 1'b1;
    exp_bank = {NUM_CHAN{HALF_SCALE}};
    seen_exp = 12'h000;
    i_host_model.send(12'h000, 1'b0);
    repeat (20) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    prev = 12'($random(seed));
    i_host_model.send(prev, 1'b0);
    note(12'h000);
    for (int a = 1; a <= 8; a++) load(a, 8'($random(seed)));
    $display("channel loads done");
    for (int a = 9; a <= 16; a++) load(a, 8'($random(seed)));
    $display("no-op codes done");
    @(posedge sys_clk);
    #2 half_scale_force_n = 1'b0;
    exp_bank = {NUM_CHAN{HALF_SCALE}};
    #1 note(seen_exp);
    load(3, 8'($random(seed)));
    @(posedge sys_clk);
    #2 half_scale_force_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    load(5, 8'($random(seed)));
    load(8, 8'hff);
    $display("preset done");
    conclude();
  end
endmodule
